// File: hdl/pmt_pkg.sv
package pmt_pkg;

  // ************************************************************
  // Register index map. Byte address is four times the index.
  // ************************************************************
  localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h0c;
  localparam logic [7:0] IDX_COUNT       = 8'h11;
  localparam logic [7:0] IDX_CONTROL     = 8'h12;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_PERIOD      = 8'h92;

  // ************************************************************
  // Field positions and reset values.
  // ************************************************************
  localparam int         MATCH_FLAG_BIT  = 1;
  localparam int         TIMER_ON_BIT    = 2;
  localparam int         POST_LSB        = 3;
  localparam int         POST_MSB        = 6;
  localparam int         PRE_LSB         = 0;
  localparam int         PRE_MSB         = 1;
  localparam logic [7:0] CONTROL_MASK    = 8'h7f;
  localparam logic [7:0] RST_COUNT       = 8'h00;
  localparam logic [7:0] RST_CONTROL     = 8'h00;
  localparam logic [7:0] RST_PERIOD      = 8'hff;
  localparam logic [7:0] RST_FLAGS       = 8'h00;
  localparam logic [7:0] RST_ENABLES     = 8'h00;

  // ************************************************************
  // Timing counts.
  // ************************************************************
  localparam int         INSTR_DIV       = 4;
  localparam logic [3:0] PRE_LAST_DIV4   = 4'h3;
  localparam logic [3:0] PRE_LAST_DIV16  = 4'hf;

endpackage

// File: hdl/pmt_instr_div.sv
`timescale 1ns/100ps
// Divides the system clock into a one-cycle instruction-rate enable.
module pmt_instr_div #(
  parameter int DIV = 4
) (
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  output logic      tick_o
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt;

  if (DIV < 2) begin : g_div_check
    $error("pmt_instr_div: DIV must be at least 2");
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt == LAST);
      cnt    <= (cnt == LAST) ? '0 : cnt + 1'b1;
    end
  end
endmodule

// File: hdl/pmt_postscaler.sv
`timescale 1ns/100ps
// Counts match pulses and emits one pulse per (ratio field + 1) matches.
module pmt_postscaler (
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       clear_i,
  input  wire logic       match_i,
  input  wire logic [3:0] ratio_i,
  output logic            out_o
);
  logic [3:0] cnt;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || clear_i) begin
      cnt   <= 4'h0;
      out_o <= 1'b0;
    end else begin
      out_o <= 1'b0;
      if (match_i) begin
        if (cnt >= ratio_i) begin
          cnt   <= 4'h0;
          out_o <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

// File: hdl/pmt_timer.sv
// Behaviour
// - The count advances on instruction-rate ticks (clock/4) divided by 1, 4 or 16 per the prescale field.
// - The count climbs from zero and, once equal to the period, loads zero on the next tick.
// - The period register is read/write and resets to all ones.
// - The count register is read/write and reset clears it.
// - Each match outside a count or control write advances a 4-bit postscaler whose terminal count sets the match interrupt flag.
// - The postscale ratio is control bits 6..3 plus one.
// - Control bit 2 enables counting; when clear the timer holds.
// - Writing the count clears the prescaler and postscaler.
// - Writing the control register clears both scalers but leaves the count.
// - Every device reset clears both scalers.
// - The raw match pulse before the postscaler is an output for the serial port.
// - Control bit 7 reads zero and the other control bits reset to zero.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/100ps
module pmt_timer
  import pmt_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             match_pulse_o,
  output logic             irq_o
);
  import pmt_pkg::*;

  // ************************************************************
  // Registers and internal signals.
  // ************************************************************
  logic [7:0] timer_count;
  logic [7:0] timer_period;
  logic [7:0] timer_control;
  logic [7:0] peripheral_irq_flags;
  logic [7:0] peripheral_irq_enables;
  logic [3:0] pre_cnt;
  logic       instr_tick;
  logic       post_out;
  logic       acked;
  logic       wr_hit;
  logic       rd_hit;
  logic [7:0] idx;
  logic       lane0;
  logic       wr_count;
  logic       wr_control;
  logic       wr_period;
  logic       wr_flags;
  logic       wr_enables;
  logic       scaler_clear;
  logic       pre_tick;
  logic [3:0] pre_last;
  logic       match_now;
  logic [7:0] next_readdata;

  assign idx          = avs_address_i[9:2];
  assign lane0        = avs_byteenable_i[0];
  assign wr_hit       = avs_write_i && acked;
  assign rd_hit       = avs_read_i && !acked;
  assign wr_count     = wr_hit && lane0 && (idx == IDX_COUNT);
  assign wr_control   = wr_hit && lane0 && (idx == IDX_CONTROL);
  assign wr_period    = wr_hit && lane0 && (idx == IDX_PERIOD);
  assign wr_flags     = wr_hit && lane0 && (idx == IDX_IRQ_FLAGS);
  assign wr_enables   = wr_hit && lane0 && (idx == IDX_IRQ_ENABLES);
  assign scaler_clear = wr_count || wr_control;

  // ************************************************************
  // Avalon slave: one wait cycle, then a one-cycle acknowledge at which a write commits.
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      acked <= 1'b0;
    end else begin
      acked <= (avs_read_i || avs_write_i) && !acked;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !acked);
    end
  end

  always_comb begin
    unique case (idx)
      IDX_COUNT:       next_readdata = timer_count;
      IDX_CONTROL:     next_readdata = timer_control & CONTROL_MASK;
      IDX_PERIOD:      next_readdata = timer_period;
      IDX_IRQ_FLAGS:   next_readdata = peripheral_irq_flags;
      IDX_IRQ_ENABLES: next_readdata = peripheral_irq_enables;
      default:         next_readdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_hit) begin
      avs_readdata_o <= {24'h00_0000, next_readdata};
    end
  end

  // ************************************************************
  // Software-owned registers.
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      timer_period <= RST_PERIOD;
    end else if (wr_period) begin
      timer_period <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      timer_control <= RST_CONTROL;
    end else if (wr_control) begin
      timer_control <= avs_writedata_i[7:0] & CONTROL_MASK;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      peripheral_irq_enables <= RST_ENABLES;
    end else if (wr_enables) begin
      peripheral_irq_enables <= avs_writedata_i[7:0];
    end
  end

  // ************************************************************
  // Prescaler.
  // ************************************************************
  pmt_instr_div #(
    .DIV (INSTR_DIV)
  ) u_div (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .tick_o    (instr_tick)
  );

  always_comb begin
    unique case (timer_control[PRE_MSB:PRE_LSB])
      2'b00:   pre_last = 4'h0;
      2'b01:   pre_last = PRE_LAST_DIV4;
      default: pre_last = PRE_LAST_DIV16;
    endcase
  end

  assign pre_tick  = timer_control[TIMER_ON_BIT] && instr_tick && (pre_cnt >= pre_last);
  assign match_now = pre_tick && (timer_count == timer_period);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || scaler_clear) begin
      pre_cnt <= 4'h0;
    end else if (timer_control[TIMER_ON_BIT] && instr_tick) begin
      pre_cnt <= (pre_cnt >= pre_last) ? 4'h0 : pre_cnt + 4'h1;
    end
  end

  // ************************************************************
  // Count and match.
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      timer_count <= RST_COUNT;
    end else if (wr_count) begin
      timer_count <= avs_writedata_i[7:0];
    end else if (pre_tick) begin
      timer_count <= (timer_count == timer_period) ? 8'h00 : timer_count + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      match_pulse_o <= 1'b0;
    end else begin
      match_pulse_o <= match_now && !wr_count;
    end
  end

  pmt_postscaler u_post (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .clear_i   (scaler_clear),
    .match_i   (match_now && !wr_count),
    .ratio_i   (timer_control[POST_MSB:POST_LSB]),
    .out_o     (post_out)
  );

  // ************************************************************
  // Flag and interrupt request. A setting event beats a clear.
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      peripheral_irq_flags <= RST_FLAGS;
    end else begin
      if (wr_flags) begin
        peripheral_irq_flags <= avs_writedata_i[7:0];
      end
      if (post_out) begin
        peripheral_irq_flags[MATCH_FLAG_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(peripheral_irq_flags & peripheral_irq_enables & 8'h02);
    end
  end

  // ************************************************************
  // Checks.
  // ************************************************************
  a_period_wrap: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (pre_tick && !wr_count && timer_count == timer_period) |=> timer_count == 8'h00)
    else $error("count did not wrap after period match");

  a_count_step: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (pre_tick && !wr_count && timer_count != timer_period) |=> timer_count == $past(timer_count) + 8'h01)
    else $error("count did not step by one");

  a_off_holds: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (!timer_control[TIMER_ON_BIT] && !wr_count) |=> $stable(timer_count))
    else $error("count moved while timer off");

  a_pre_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    scaler_clear |=> pre_cnt == 4'h0)
    else $error("prescaler not cleared by write");

  a_ctrl_keeps: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_control && !pre_tick) |=> $stable(timer_count))
    else $error("control write changed count");

  a_bit7_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    timer_control[7] == 1'b0)
    else $error("control bit 7 set");

  a_flag_sets: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    post_out |=> peripheral_irq_flags[MATCH_FLAG_BIT])
    else $error("flag not set by postscaler");

  a_match_out: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (match_now && !wr_count) |=> match_pulse_o)
    else $error("match pulse missing");

  a_match_quiet: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !(match_now && !wr_count) |=> !match_pulse_o)
    else $error("match pulse without match");

  a_irq_follow: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (peripheral_irq_flags[1] && peripheral_irq_enables[1]) |=> irq_o)
    else $error("irq did not follow flag and enable");

  a_div_one: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (pre_tick && timer_control[1:0] == 2'b00) |-> pre_cnt == 4'h0)
    else $error("prescale 1:1 wrong");

  a_div4_range: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (timer_control[PRE_MSB:PRE_LSB] == 2'b01) |-> pre_cnt <= PRE_LAST_DIV4)
    else $error("prescale 1:4 counter out of range");

  a_div4_tick: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (pre_tick && timer_control[PRE_MSB:PRE_LSB] == 2'b01) |-> pre_cnt == PRE_LAST_DIV4)
    else $error("prescale 1:4 wrong");

  a_div16_tick: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (pre_tick && timer_control[PRE_MSB]) |-> pre_cnt == PRE_LAST_DIV16)
    else $error("prescale 1:16 wrong");

  a_tick_rate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    pre_tick |-> instr_tick)
    else $error("count tick off the instruction rate");

  a_pre_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !timer_control[TIMER_ON_BIT] |-> !pre_tick)
    else $error("tick while timer off");

  a_count_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_count |=> timer_count == $past(avs_writedata_i[7:0]))
    else $error("count write lost");

  a_period_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_period |=> timer_period == $past(avs_writedata_i[7:0]))
    else $error("period write lost");

  a_ctrl_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_control |=> timer_control == ($past(avs_writedata_i[7:0]) & CONTROL_MASK))
    else $error("control write lost");

  a_post_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    scaler_clear |=> !post_out)
    else $error("postscaler fired across a clear");

  a_post_pulse: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    post_out |=> !post_out)
    else $error("postscaler output longer than one cycle");

  a_post_cause: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    post_out |-> $past(match_now && !wr_count))
    else $error("postscaler fired without a match");

  a_flag_holds: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (peripheral_irq_flags[MATCH_FLAG_BIT] && !wr_flags) |=> peripheral_irq_flags[MATCH_FLAG_BIT])
    else $error("flag dropped without a clear");

  a_flag_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_flags && !post_out) |=> peripheral_irq_flags == $past(avs_writedata_i[7:0]))
    else $error("flag write lost");

  a_irq_quiet: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !(peripheral_irq_flags[MATCH_FLAG_BIT] && peripheral_irq_enables[MATCH_FLAG_BIT]) |=> !irq_o)
    else $error("irq without flag and enable");

  a_reset_pre: assert property (@(posedge sys_clk_i)
    sys_rst_i |=> pre_cnt == 4'h0)
    else $error("reset left prescaler running");

  a_reset_post: assert property (@(posedge sys_clk_i)
    sys_rst_i |=> !post_out)
    else $error("reset left postscaler output");

  a_reset_count: assert property (@(posedge sys_clk_i)
    sys_rst_i |=> timer_count == RST_COUNT)
    else $error("reset left count");

  a_reset_period: assert property (@(posedge sys_clk_i)
    sys_rst_i |=> timer_period == RST_PERIOD)
    else $error("reset left period");

  a_reset_ctrl: assert property (@(posedge sys_clk_i)
    sys_rst_i |=> timer_control == RST_CONTROL)
    else $error("reset left control");

  a_reset_flags: assert property (@(posedge sys_clk_i)
    sys_rst_i |=> peripheral_irq_flags == RST_FLAGS)
    else $error("reset left flags");

  a_reset_irq: assert property (@(posedge sys_clk_i)
    sys_rst_i |=> !irq_o)
    else $error("reset left irq");

endmodule

// File: sim/period_match_timer_tb.sv
`timescale 1ns/100ps
module period_match_timer_tb;
  import pmt_pkg::*;

  localparam logic [9:0] A_FLAGS = {IDX_IRQ_FLAGS, 2'b00};
  localparam logic [9:0] A_COUNT = {IDX_COUNT, 2'b00};
  localparam logic [9:0] A_CTRL  = {IDX_CONTROL, 2'b00};
  localparam logic [9:0] A_ENAB  = {IDX_IRQ_ENABLES, 2'b00};
  localparam logic [9:0] A_PER   = {IDX_PERIOD, 2'b00};
  localparam logic [9:0] A_NONE  = 10'h3fc;

  logic        clk;
  logic        rst;
  logic [9:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wreq;
  logic        match;
  logic        irq;
  logic [31:0] got;
  int          n;
  int          fail_count;
  int          check_count;
  int          pre [4] = '{1, 4, 16, 16};
  logic [3:0]  rs [3] = '{4'h0, 4'h1, 4'hf};

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  pmt_timer dut (
    .sys_clk_i        (clk),
    .sys_rst_i        (rst),
    .avs_address_i    (addr),
    .avs_read_i       (rd),
    .avs_write_i      (wr),
    .avs_writedata_i  (wdata),
    .avs_byteenable_i (be),
    .avs_readdata_o   (rdata),
    .avs_waitrequest_o(wreq),
    .match_pulse_o    (match),
    .irq_o            (irq)
  );

  // ************************************************************
  // Reporting.
  // ************************************************************
  task complete_run;
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // ************************************************************
  // Bus and event helpers.
  // ************************************************************
  // Called just after a rising edge. The request is held until waitrequest is sampled low at a rising edge,
  // released there, and one more edge passes before the next call may drive again.
  task automatic bus(input logic is_wr, input logic [9:0] a, input logic [7:0] d);
    int i;
    addr  <= a;
    wdata <= {24'h00_0000, d};
    wr    <= is_wr;
    rd    <= ~is_wr;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    if (i == 50) begin
      fail_count++;
      complete_run();
    end
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(got, {24'h00_0000, e});
  endtask

  // Counts cycles up to the next match pulse into n.
  task automatic wait_match;
    int i;
    n = 0;
    for (i = 0; i < 2000; i++) begin
      @(posedge clk);
      n++;
      if (match === 1'b1) break;
    end
    if (i == 2000) begin
      fail_count++;
      complete_run();
    end
  endtask

  task automatic count_to_irq(input int e);
    int i;
    int m;
    m = 0;
    for (i = 0; i < 4000; i++) begin
      @(posedge clk);
      if (match === 1'b1) m++;
      if (irq === 1'b1) break;
    end
    if (i == 4000) begin
      fail_count++;
      complete_run();
    end
    chk(m, e);
  endtask

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    rst         = 1'b1;
    addr        = 10'h000;
    rd          = 1'b0;
    wr          = 1'b0;
    wdata       = 32'h0000_0000;
    be          = 4'hf;
    fail_count  = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdchk(A_FLAGS, 8'h00);
    rdchk(A_COUNT, 8'h00);
    rdchk(A_CTRL, 8'h00);
    rdchk(A_ENAB, 8'h00);
    rdchk(A_PER, 8'hff);
    rdchk(A_NONE, 8'h00);
    bus(1'b1, A_CTRL, 8'hfb);
    rdchk(A_CTRL, 8'h7b);
    bus(1'b1, A_PER, 8'h5a);
    rdchk(A_PER, 8'h5a);
    bus(1'b1, A_COUNT, 8'h05);
    bus(1'b1, A_CTRL, 8'h00);
    rdchk(A_COUNT, 8'h05);
    repeat (100) @(posedge clk);
    rdchk(A_COUNT, 8'h05);
    bus(1'b1, A_PER, 8'h03);
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, A_CTRL, {5'b00001, p[1:0]});
      wait_match();
      wait_match();
      chk(n, INSTR_DIV * pre[p] * 4);
    end
    bus(1'b1, A_PER, 8'h07);
    bus(1'b1, A_ENAB, 8'h02);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, A_CTRL, 8'h00);
      bus(1'b1, A_FLAGS, 8'h00);
      bus(1'b1, A_COUNT, 8'h00);
      bus(1'b1, A_CTRL, {1'b0, rs[k], 3'b100});
      count_to_irq(rs[k] + 1);
    end
    rdchk(A_FLAGS, 8'h02);
    bus(1'b1, A_ENAB, 8'h00);
    repeat (4) @(posedge clk);
    chk(irq, 1'b0);
    bus(1'b1, A_FLAGS, 8'h00);
    rdchk(A_FLAGS, 8'h00);
    bus(1'b1, A_ENAB, 8'h02);
    bus(1'b1, A_CTRL, 8'h0c);
    wait_match();
    bus(1'b1, A_CTRL, 8'h0c);
    count_to_irq(2);
    bus(1'b1, A_FLAGS, 8'h00);
    wait_match();
    bus(1'b1, A_COUNT, 8'h00);
    count_to_irq(2);
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdchk(A_COUNT, 8'h00);
    rdchk(A_PER, 8'hff);
    rdchk(A_CTRL, 8'h00);
    rdchk(A_FLAGS, 8'h00);
    be <= 4'he;
    bus(1'b1, A_PER, 8'h11);
    be <= 4'hf;
    rdchk(A_PER, 8'hff);
    complete_run();
  end
endmodule
